// file: src/cru_modstep.sv
module cru_modstep
(
    input  wire logic [127:0] r,      // Running remainder, below m
    input  wire logic [127:0] m,      // Modulus, nonzero
    input  wire logic         xbit,   // Multiplier bit, msb first
    input  wire logic [127:0] y,      // Multiplicand, not above m
    output logic      [127:0] r_next  // 2r + xbit*y reduced mod m
);
    import cru_pkg::*;

    logic [128:0] dbl;
    logic [128:0] sum;

    // One interleaved step; both partial values stay below 2m, so a
    // single conditional subtraction after each add is enough.
    always_comb begin
        dbl = {r, 1'b0};
        if (dbl >= {1'b0, m}) begin
            dbl = dbl - {1'b0, m};
        end
        sum = dbl + (xbit ? {1'b0, y} : 129'h0);
        if (sum >= {1'b0, m}) begin
            sum = sum - {1'b0, m};
        end
        r_next = sum[127:0];
    end
endmodule

// file: src/cru_pkg.sv
package cru_pkg;
    // -------------------------------------------------------------
    // Arithmetic engine memory map (word addresses)
    // -------------------------------------------------------------
    localparam int              WORD_W    = 32;
    localparam int              OPND_W    = 128;
    localparam int              RAM_WORDS = 32;
    localparam int              RAM_AW    = 5;
    localparam logic [RAM_AW-1:0] A_BASE   = 5'h00;
    localparam logic [RAM_AW-1:0] B_BASE   = 5'h04;
    localparam logic [RAM_AW-1:0] M_BASE   = 5'h08;
    localparam logic [RAM_AW-1:0] RES_BASE = 5'h10;
    localparam logic [RAM_AW-1:0] TMP_BASE = 5'h18;
    localparam logic [2:0]      RES_LAST  = 3'h7;
    localparam logic [2:0]      TMP_LAST  = 3'h3;
    localparam logic [6:0]      BIT_LAST  = 7'h7f;

    // -------------------------------------------------------------
    // Command codes
    // -------------------------------------------------------------
    localparam logic [2:0] CMD_ADD = 3'h1;
    localparam logic [2:0] CMD_SUB = 3'h2;
    localparam logic [2:0] CMD_MUL = 3'h3;
    localparam logic [2:0] CMD_MOD = 3'h4;
    localparam logic [2:0] CMD_EXP = 3'h5;

    // -------------------------------------------------------------
    // Random word generator
    // -------------------------------------------------------------
    localparam int              FIFO_DEPTH = 16;
    localparam logic [4:0]      FIFO_FULL  = 5'h10;
    localparam logic [4:0]      WORD_LAST  = 5'h1f;
    localparam logic [127:0]    LFSR_SEED  = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3211;
    localparam logic [127:0]    LFSR_TAPS  = 128'ha000_0000_0000_0000_0000_0050_0000_0000;
    localparam logic [41:0]     PN_SEED    = 42'h2aa_5555_aaa5;
    localparam logic [41:0]     PN_TAPS    = 42'h300_000c_0000;

    // -------------------------------------------------------------
    // Types
    // -------------------------------------------------------------
    typedef struct packed {
        logic              ram_we;
        logic [RAM_AW-1:0] addr;
        logic [WORD_W-1:0] wdata;
        logic              cmd_we;
        logic [2:0]        cmd;
    } cru_host_req_type;

    typedef struct packed {
        logic busy;
        logic done;
        logic carry;
        logic mod_zero;
        logic cmd_ignored;
        logic bad_cmd;
    } cru_status_type;

    typedef enum logic [1:0] {st_idle, st_exec, st_save, st_store}
        cru_state_type;
    typedef enum logic [1:0] {ph_red, ph_sqr, ph_mul} cru_phase_type;

    typedef struct packed {
        cru_state_type                      st;
        cru_phase_type                      ph;
        logic [2:0]                         op;
        logic [6:0]                         cnt;
        logic [6:0]                         e;
        logic [2:0]                         idx;
        logic [OPND_W-1:0]                  a;
        logic [OPND_W-1:0]                  b;
        logic [OPND_W-1:0]                  m;
        logic [OPND_W-1:0]                  base;
        logic [OPND_W-1:0]                  res;
        logic [OPND_W-1:0]                  t;
        logic [2*OPND_W-1:0]                prod;
        logic                               done;
        logic                               carry;
        logic                               mod_zero;
        logic                               cmd_ignored;
        logic                               bad_cmd;
        logic [WORD_W-1:0]                  rdata;
        logic [RAM_WORDS-1:0][WORD_W-1:0]   ram;
    } cru_eng_type;

    typedef struct packed {
        logic [127:0]                       lfsr;
        logic [41:0]                        pn;
        logic [31:0]                        sh;
        logic [4:0]                         cnt;
        logic [FIFO_DEPTH-1:0][WORD_W-1:0]  mem;
        logic [3:0]                         wr_ptr;
        logic [3:0]                         rd_ptr;
        logic [4:0]                         count;
        logic [WORD_W-1:0]                  rdata;
        logic                               rvalid;
    } cru_rng_type;
endpackage

// file: src/cru_rng.sv
module cru_rng
(
    input  wire logic        ref_clk,   // System clock
    input  wire logic        arst_n,    // Asynchronous reset, low
    input  wire logic        rnd_rd,    // Read one random word
    output logic [31:0]      rnd_data,  // Word read, registered
    output logic             rnd_valid, // rnd_data updated this cycle
    output logic             rnd_avail  // FIFO holds a word
);
    import cru_pkg::*;

    cru_rng_type q;
    cru_rng_type d;
    logic        fb;
    logic        tick;
    logic        push;
    logic        pop;
    logic [31:0] word;
    logic [31:0] head;

    always_comb begin
        d        = q;
        d.rvalid = 1'b0;
        d.pn     = {q.pn[40:0], ^(q.pn & PN_TAPS)};              // [R11]
        fb       = ^(q.lfsr & LFSR_TAPS) ^ q.pn[41];            // [R10]
        d.lfsr   = {q.lfsr[126:0], fb};
        word     = {q.sh[30:0], q.lfsr[127]};
        d.sh     = word;                                         // [R7]
        d.cnt    = q.cnt + 5'h01;
        tick     = (q.cnt == WORD_LAST);                         // [R8]
        // A full FIFO drops the finished word rather than overwrite.
        push     = tick && (q.count != FIFO_FULL);               // [R13]
        pop      = rnd_rd && (q.count != 5'h00);
        head     = q.mem[q.rd_ptr];
        if (push) begin
            d.mem[q.wr_ptr] = word;                              // [R9]
            d.wr_ptr        = q.wr_ptr + 4'h1;
        end
        if (pop) begin
            d.rdata  = head;                                     // [R7]
            d.rvalid = 1'b1;
            d.rd_ptr = q.rd_ptr + 4'h1;
        end
        if (push && !pop) begin
            d.count = q.count + 5'h01;
        end else if (pop && !push) begin
            d.count = q.count - 5'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{lfsr: LFSR_SEED, pn: PN_SEED, default: '0};
        end else begin
            q <= d;
        end
    end

    assign rnd_data  = q.rdata;
    assign rnd_valid = q.rvalid;
    assign rnd_avail = (q.count != 5'h00);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_word_period: assert property (tick |=> !tick ##31 tick) // [R8]
        else $error("random word not completed every 32 cycles");
    a_fifo_bound: assert property (q.count <= FIFO_FULL) // [R9]
        else $error("random FIFO count above sixteen");
    a_full_hold: assert property ( // [R13]
        (q.count == FIFO_FULL && !rnd_rd) |=>
            (q.count == FIFO_FULL) && $stable(q.mem))
        else $error("full random FIFO changed without a read");
    a_read_word: assert property ( // [R7]
        (rnd_rd && rnd_avail) |=> rnd_valid && rnd_data == $past(head))
        else $error("random read did not return the FIFO head");
    a_lfsr_live: assert property ((q.lfsr != '0) || (q.pn != '0)) // [R10]
        else $error("generator state collapsed to zero");
    a_pn_live: assert property (q.pn != '0) // [R11]
        else $error("entropy sequence stuck at zero");
endmodule

// file: src/cru_top.sv
// Functional notes
// [R1] The engine offers add, subtract, multiply, reduce and modexp.
// [R2] Operands and results sit little-endian in engine RAM, temps too.
// [R3] The engine runs one operation at a time, never overlapping.
// [R4] The host issues a command only after the previous one finished.
// [R5] The host loads RAM first; only a command write starts work.
// [R6] On finishing, status is updated and the engine idles.
// [R7] Random bits shift into 32-bit FIFO words read one by one.
// [R8] A new random word is completed every 32 clock cycles.
// [R9] The random FIFO holds up to sixteen words.
// [R10] The random source is a 128-stage shift register.
// [R11] It takes one entropy bit from a maximal 42-bit sequence.
// [R12] The host should hash generator output before use.
// [R13] A full random FIFO drops new words and overwrites none.
// [R14] A command written while busy is ignored; status shows busy.
module cru_top
(
    input  wire logic                      ref_clk,   // System clock
    input  wire logic                      arst_n,    // Async reset, low
    input  wire cru_pkg::cru_host_req_type host,      // RAM and command
    output logic [cru_pkg::WORD_W-1:0]     ram_rdata, // Word at last addr
    output cru_pkg::cru_status_type        status,    // Engine status
    input  wire logic                      rnd_rd,    // Random word read
    output logic [cru_pkg::WORD_W-1:0]     rnd_data,  // Random word
    output logic                           rnd_valid, // rnd_data fresh
    output logic                           rnd_avail  // Random word ready
);
    import cru_pkg::*;

    // -------------------------------------------------------------
    // Engine state and helpers
    // -------------------------------------------------------------
    cru_eng_type         q;
    cru_eng_type         d;
    logic [127:0]        step_r;
    logic                step_x;
    logic [127:0]        step_y;
    logic [128:0]        sum;
    logic [128:0]        diff;
    logic [3:0][31:0]    res_w;
    logic [7:0][31:0]    prod_w;
    logic                accept;
    logic                valid_cmd;

    assign valid_cmd = (host.cmd >= CMD_ADD) && (host.cmd <= CMD_EXP);
    assign accept    = (q.st == st_idle) && host.cmd_we && valid_cmd;
    assign sum       = {1'b0, q.a} + {1'b0, q.b};
    assign diff      = {1'b0, q.a} - {1'b0, q.b};
    assign res_w     = q.res;
    assign prod_w    = q.prod;

    // Reduction walks the first operand against 1; the exponent
    // phases square the accumulator or multiply it by the base.
    always_comb begin
        case (q.ph)
            ph_sqr: begin
                step_x = q.res[q.cnt];
                step_y = q.res;
            end
            ph_mul: begin
                step_x = q.res[q.cnt];
                step_y = q.base;
            end
            default: begin
                step_x = q.a[q.cnt];
                step_y = 128'h1;
            end
        endcase
    end

    cru_modstep u_step (
        .r      (q.t),
        .m      (q.m),
        .xbit   (step_x),
        .y      (step_y),
        .r_next (step_r)
    );

    // -------------------------------------------------------------
    // Engine sequencer
    // -------------------------------------------------------------
    always_comb begin
        d       = q;
        d.done  = 1'b0;
        d.rdata = q.ram[host.addr];
        // Writes outside idle are dropped so the engine owns its RAM.
        if (host.cmd_we && q.st != st_idle) begin
            d.cmd_ignored = 1'b1;                                // [R14]
        end
        case (q.st)
            st_idle: begin
                if (host.ram_we) begin
                    d.ram[host.addr] = host.wdata;               // [R5]
                end
                if (accept) begin
                    d.st          = st_exec;                     // [R5]
                    d.op          = host.cmd;
                    d.a           = q.ram[A_BASE +: 4];          // [R2]
                    d.b           = q.ram[B_BASE +: 4];
                    d.m           = q.ram[M_BASE +: 4];
                    d.ph          = ph_red;
                    d.cnt         = BIT_LAST;
                    d.e           = BIT_LAST;
                    d.t           = '0;
                    d.prod        = '0;
                    d.carry       = 1'b0;
                    d.mod_zero    = 1'b0;
                    d.cmd_ignored = 1'b0;
                    d.bad_cmd     = 1'b0;
                end else if (host.cmd_we) begin
                    d.bad_cmd = 1'b1;
                end
            end
            st_exec: begin
                d.idx = 3'h0;
                case (q.op)                                      // [R1]
                    CMD_ADD: begin
                        d.prod  = {128'h0, sum[127:0]};
                        d.carry = sum[128];
                        d.st    = st_store;
                    end
                    CMD_SUB: begin
                        d.prod  = {128'h0, diff[127:0]};
                        d.carry = diff[128];
                        d.st    = st_store;
                    end
                    CMD_MUL: begin
                        if (q.a[q.cnt]) begin
                            d.prod = q.prod + ({128'h0, q.b} << q.cnt);
                        end
                        d.cnt = q.cnt - 7'h01;
                        if (q.cnt == 7'h00) begin
                            d.st = st_store;
                        end
                    end
                    default: begin
                        if (q.m == '0) begin
                            d.mod_zero = 1'b1;
                            d.st       = st_store;
                        end else begin
                            d.t   = step_r;
                            d.cnt = q.cnt - 7'h01;
                            if (q.cnt == 7'h00) begin
                                d.t   = '0;
                                d.cnt = BIT_LAST;
                                case (q.ph)
                                    ph_red: begin
                                        if (q.op == CMD_MOD) begin
                                            d.prod = {128'h0, step_r};
                                            d.st   = st_store;
                                        end else begin
                                            d.base = step_r;
                                            d.res  = (q.m == 128'h1) ?
                                                     128'h0 : 128'h1;
                                            d.ph   = ph_sqr;
                                        end
                                    end
                                    ph_sqr: begin
                                        d.res = step_r;
                                        if (q.b[q.e]) begin
                                            d.ph = ph_mul;
                                        end else begin
                                            d.st = st_save;
                                        end
                                    end
                                    default: begin
                                        d.res = step_r;
                                        d.st  = st_save;
                                    end
                                endcase
                            end
                        end
                    end
                endcase
            end
            st_save: begin
                // The running accumulator is parked in the temp area.
                d.ram[TMP_BASE + {3'h0, q.idx[1:0]}] = res_w[q.idx[1:0]]; // [R2]
                d.idx = q.idx + 3'h1;
                if (q.idx == TMP_LAST) begin
                    d.idx = 3'h0;
                    if (q.e == 7'h00) begin
                        d.prod = {128'h0, q.res};
                        d.st   = st_store;
                    end else begin
                        d.e  = q.e - 7'h01;
                        d.ph = ph_sqr;
                        d.st = st_exec;
                    end
                end
            end
            st_store: begin
                d.ram[RES_BASE + {2'h0, q.idx}] = prod_w[q.idx];  // [R2]
                d.idx = q.idx + 3'h1;
                if (q.idx == RES_LAST) begin
                    d.st   = st_idle;                            // [R6]
                    d.done = 1'b1;                               // [R6]
                end
            end
            default: begin
                d.st = st_idle;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{st: st_idle, ph: ph_red, default: '0};
        end else begin
            q <= d;
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    assign ram_rdata          = q.rdata;
    assign status.busy        = (q.st != st_idle);               // [R14]
    assign status.done        = q.done;
    assign status.carry       = q.carry;
    assign status.mod_zero    = q.mod_zero;
    assign status.cmd_ignored = q.cmd_ignored;
    assign status.bad_cmd     = q.bad_cmd;

    // -------------------------------------------------------------
    // Random word generator
    // -------------------------------------------------------------
    cru_rng u_rng (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .rnd_rd    (rnd_rd),
        .rnd_data  (rnd_data),
        .rnd_valid (rnd_valid),
        .rnd_avail (rnd_avail)
    );

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_start(logic [2:0] c);
        accept && host.cmd == c;
    endsequence

    sequence s_busy_run;
        status.busy ##9 status.done;
    endsequence

    a_cmd_start: assert property (accept |=> status.busy) // [R5]
        else $error("accepted command did not start the engine");
    a_idle_hold: assert property ( // [R6]
        (!status.busy && !accept) |=> !status.busy)
        else $error("engine left idle without a command");
    a_done_idle: assert property ( // [R6]
        status.done |-> !status.busy && $past(q.st) == st_store)
        else $error("done without returning to idle");
    a_busy_ignore: assert property ( // [R14]
        (status.busy && host.cmd_we) |=>
            status.cmd_ignored && $stable(q.op) && $stable(q.a))
        else $error("command taken while busy");
    a_add_time: assert property ( // [R1]
        s_start(CMD_ADD) |=> s_busy_run)
        else $error("add did not finish in ten cycles");
    a_mul_time: assert property ( // [R3]
        s_start(CMD_MUL) |=> (status.busy && !status.done) ##136
            status.done)
        else $error("multiply did not finish in 137 cycles");
    a_result_word: assert property ( // [R2]
        (status.done && q.op == CMD_ADD) |->
            q.ram[RES_BASE] == q.a[31:0] + q.b[31:0])
        else $error("low result word not stored first");
endmodule

// file: verification/cru_host_model.sv
module cru_host_model
(
    input  wire logic                    ref_clk,   // System clock
    output cru_pkg::cru_host_req_type    host,      // RAM and command
    output logic                         rnd_rd,    // Random word read
    input  wire logic [31:0]             ram_rdata, // RAM read word
    input  wire logic [31:0]             rnd_data,  // Random word
    input  wire logic                    rnd_valid, // Random word fresh
    input  wire cru_pkg::cru_status_type status     // Engine status
);
    timeunit 1ns;
    timeprecision 1ps;
    import cru_pkg::*;

    // ------------------------------------------------------------
    // Host tasks, each change made just after a rising edge
    // ------------------------------------------------------------
    initial begin
        host = '0;
        rnd_rd = 1'b0;
    end

    task automatic load(input logic [4:0] base, input logic [127:0] v);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            host.ram_we <= 1'b1;
            host.addr <= base + 5'(i);
            host.wdata <= v[32*i +: 32];
        end
        @(posedge ref_clk);
        host.ram_we <= 1'b0;
        // Released data is inverted so a late sample shows wrong data.
        host.wdata <= ~v[127:96];
    endtask

    task automatic command(input logic [2:0] code, input bit idle, output bit ok);
        ok = 1'b1;
        for (int i = 0; i < 5000 && idle; i++) begin
            @(negedge ref_clk);
            if (status.busy === 1'b0) break;
            ok = (i < 4999);
        end
        @(posedge ref_clk);
        host.cmd_we <= 1'b1;
        host.cmd <= code;
        @(posedge ref_clk);
        host.cmd_we <= 1'b0;
        host.cmd <= ~code;
    endtask

    task automatic read(input logic [4:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        host.addr <= a;
        @(posedge ref_clk);
        @(negedge ref_clk);
        d = ram_rdata;
    endtask

    task automatic burst(input int n, output int cnt, inout logic [31:0] d);
        cnt = 0;
        @(posedge ref_clk);
        rnd_rd <= 1'b1;
        for (int i = 0; i <= n; i++) begin
            if (i == n - 1) @(posedge ref_clk);
            if (i == n - 1) rnd_rd <= 1'b0;
            @(negedge ref_clk);
            if (rnd_valid === 1'b1) d = rnd_data;
            if (rnd_valid === 1'b1) cnt++;
        end
    endtask
endmodule

// file: verification/crypto_exponent_and_rng_unit_test.sv
module crypto_exponent_and_rng_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    import cru_pkg::*;

    logic             ref_clk;
    logic             arst_n;
    cru_host_req_type host;
    logic             rnd_rd;
    logic [31:0]      ram_rdata;
    logic [31:0]      rnd_data;
    cru_status_type   status;
    logic             rnd_valid;
    logic             rnd_avail;
    int               err_total = 0;
    int               checked = 0;
    int               cyc = 0;

    cru_top u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .host(host),
        .ram_rdata(ram_rdata), .status(status), .rnd_rd(rnd_rd),
        .rnd_data(rnd_data), .rnd_valid(rnd_valid), .rnd_avail(rnd_avail));
    cru_host_model u_host (.ref_clk(ref_clk), .host(host), .rnd_rd(rnd_rd),
        .ram_rdata(ram_rdata), .rnd_data(rnd_data), .rnd_valid(rnd_valid),
        .status(status));

    // ------------------------------------------------------------
    // Clock, checks and scenarios
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    task automatic stop_test();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic fail(input string msg);
        err_total++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask
    task automatic cmp_val(input logic [255:0] got, exp, input string msg);
        checked++;
        if (got !== exp) fail(msg);
    endtask
    task automatic cmp_cnt(input int got, lo, hi, input string msg);
        checked++;
        if (got < lo || got > hi) fail(msg);
    endtask
    task automatic wait_done(output int n);
        for (n = 1; n < 20000; n++) begin
            @(negedge ref_clk);
            if (status.done === 1'b1) return;
        end
        fail("no done");
        stop_test();
    endtask
    task automatic read_res(output logic [255:0] r);
        for (int i = 0; i < 8; i++) u_host.read(RES_BASE + 5'(i), r[32*i +: 32]);
    endtask

    task automatic test_op(input logic [2:0] code, input logic [127:0] a, b,
        m, input logic [255:0] exp, input int fsel, input logic flag, int cn);
        logic [255:0] r;
        bit           ok;
        int           n;
        u_host.load(A_BASE, a);
        u_host.load(B_BASE, b);
        u_host.load(M_BASE, m);
        @(negedge ref_clk);
        cmp_val(256'(status.busy), 256'h0, "load started");
        u_host.command(code, 1'b1, ok);
        wait_done(n);
        if (cn > 0) cmp_cnt(n, cn, cn, "done time");
        cmp_val(256'({status.busy, status.bad_cmd}), 256'h0, "status");
        if (fsel == 1) cmp_val(256'(status.carry), 256'(flag), "carry");
        if (fsel == 2) cmp_val(256'(status.mod_zero), 256'(flag), "mz");
        read_res(r);
        cmp_val(r, exp, "result");
        cmp_val(256'(status.busy), 256'h0, "left idle");
        $display("test op %0d finished", code);
    endtask

    task automatic test_busy();
        logic [255:0] r;
        bit           ok;
        int           n;
        u_host.load(A_BASE, 128'h5);
        u_host.load(B_BASE, 128'h3);
        u_host.command(CMD_ADD, 1'b1, ok);
        @(negedge ref_clk);
        cmp_val(256'(status.busy), 256'h1, "busy");
        u_host.command(CMD_MUL, 1'b0, ok);
        @(negedge ref_clk);
        cmp_val(256'({status.busy, status.cmd_ignored}), 256'h3, "ign");
        wait_done(n);
        cmp_cnt(n, 7, 7, "done time");
        read_res(r);
        cmp_val(r, 256'h8, "result");
        $display("test busy finished");
    endtask

    task automatic test_rng();
        logic [31:0] w1, w2;
        int          c, t1, t2;
        u_host.burst(20, c, w1);
        cmp_cnt(c, 16, 17, "depth");
        for (int k = 0; k < 4 && rnd_avail === 1'b1; k++) u_host.burst(1, c, w1);
        for (t1 = 0; t1 < 99 && rnd_avail !== 1'b1; t1++) @(negedge ref_clk);
        t1 = cyc;
        u_host.burst(1, c, w1);
        cmp_cnt(c, 1, 1, "read one");
        for (t2 = 0; t2 < 99 && rnd_avail !== 1'b1; t2++) @(negedge ref_clk);
        t2 = cyc;
        cmp_cnt(t2 - t1, 32, 32, "period");
        u_host.burst(1, c, w2);
        cmp_val(256'(w1 === w2), 256'h0, "same word");
        u_host.burst(1, c, w2);
        cmp_cnt(c, 0, 0, "empty read");
        $display("test rng finished");
    endtask

    initial begin
        bit           ok;
        logic [127:0] a, b, m;
        logic [31:0]  w;
        arst_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(negedge ref_clk);
        cmp_val(256'({status, rnd_avail, rnd_valid}), 256'h0, "reset");
        u_host.read(5'h00, w);
        cmp_val(256'(w), 256'h0, "ram clear");
        // Codes 6, 7 and 0 from one loop: 8 wraps to 0 in three bits.
        for (int c = 6; c < 9; c++) begin
            u_host.command(3'(c), 1'b1, ok);
            @(negedge ref_clk);
            cmp_val(256'({status.busy, status.bad_cmd}), 256'h1, "bad");
        end
        a = '1;
        test_op(CMD_ADD, a, 128'h1, 128'h0, 256'h0, 1, 1'b1, 10);
        test_op(CMD_SUB, 128'h5, 128'h7, 128'h0,
            {128'h0, 128'h5 - 128'h7}, 1, 1'b1, 10);
        a = 128'h1234_5678_9abc_def0_0fed_cba9_8765_4321;
        b = 128'hffff_0000_ffff_0000_1111_2222_3333_4444;
        m = 128'h3b9a_ca07;
        test_op(CMD_MUL, a, b, m, 256'(a) * 256'(b), 0, 1'b0, 137);
        test_op(CMD_MOD, a, b, m, 256'(a % m), 2, 1'b0, 137);
        test_op(CMD_MOD, a, b, 128'h0, 256'h0, 2, 1'b1, 0);
        test_op(CMD_EXP, 128'h3, 128'h5, 128'h7, 256'h5, 2, 1'b0, 0);
        test_busy();
        test_rng();
        stop_test();
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        fail("timeout");
        stop_test();
    end
endmodule
